// >>> common/i2cee_pkg.sv
// Constants shared by the two-wire serial EEPROM slave and its bench
package i2cee_pkg;
  localparam logic [3:0] TYPE_PATTERN   = 4'ha;     // Fixed slave type code
  localparam int         PAGE_BITS      = 4;        // Low address bits within a page
  localparam int         PAGE_BYTES     = 16;       // Page buffer size
  localparam logic [7:0] ERASED_BYTE    = 8'hff;    // Delivery state of each byte
  localparam int         CLK_HZ         = 40000000; // System clock rate
  localparam int         PROG_TIME_US   = 5000;     // Internal program time in microseconds
  localparam int         PROG_CYCLES    = (PROG_TIME_US * (CLK_HZ / 1000000)); // Cycles
  typedef enum logic [2:0] {
    I2CEE_IDLE  = 3'b000,  // Waiting for START
    I2CEE_ADDR  = 3'b001,  // Shifting slave address
    I2CEE_WORD  = 3'b011,  // Shifting memory address
    I2CEE_WDATA = 3'b010,  // Shifting write data
    I2CEE_RDATA = 3'b110,  // Shifting read data out
    I2CEE_SKIP  = 3'b111   // Not addressed, wait for START or STOP
  } i2cee_state_e;
endpackage : i2cee_pkg

// >>> verification/i2cee_master.sv
// Two-wire bus master model driving SCL and pulling SDA
`timescale 1ns/10ps
`default_nettype none
module i2cee_master (
  input  wire logic clk,     // Bench clock
  input  wire logic sda,     // Resolved SDA wire
  output var  logic scl,     // Serial clock
  output var  logic sda_low  // High while pulling SDA low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Quarter of the 200 ns SCL period
  task automatic q();
    repeat (2) @(posedge clk);
  endtask : q
  // Start, from idle or repeated
  task automatic start();
    sda_low <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b1;
    q();
    scl <= 1'b0;
    q();
  endtask : start
  // Stop, then bus free time before any new start
  task automatic stop();
    sda_low <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b0;
    q();
    q();
  endtask : stop
  // One bit: SDA set while SCL low, sampled mid high
  task automatic bitx(input logic b, output logic s);
    sda_low <= !b;
    q();
    scl <= 1'b1;
    q();
    s = sda;
    q();
    scl <= 1'b0;
    q();
  endtask : bitx
  // Byte MSB first; ninth bit is the master's ack or NoACK
  task automatic byte_x(input logic [7:0] d, input logic nak, output logic [7:0] r,
                        output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], s);
      r[i] = s;
    end
    bitx(nak, s);
    ack = !s;
  endtask : byte_x
endmodule : i2cee_master
`default_nettype wire

// >>> verification/i2cee_slave_bench.sv
// Self-checking bench for the EEPROM slave
`timescale 1ns/10ps
`default_nettype none
module i2cee_slave_bench;
  localparam int PROG = 150;  // Short program time
  logic       clk;            // 40 MHz clock
  logic       rst;            // Power-on reset
  logic       wp;             // Protect pin
  logic [2:0] strap;          // Select straps
  logic       sda_out;        // Device SDA value
  logic       sda_oe;         // Device SDA pull
  logic       busy;           // Program flag
  logic       scl;            // Master clock
  logic       m_low;          // Master SDA pull
  wire  logic sda;            // Pulled-up wire
  int         n_fail;         // Mismatches
  int         checks;         // Comparisons
  logic [7:0] exp_pg [16];    // Expected bytes
  logic [7:0] bad [3];        // Foreign addresses
  logic [7:0] dev_w;          // Own write address
  logic [7:0] d;              // Read value
  logic       ok;             // Ack result
  assign sda = !(m_low || (sda_oe && !sda_out));
  i2cee_slave #(.LARGE_VARIANT(1'b0), .PROG_CYCLES(PROG)) i2cee_slave_inst (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .strap_select_bit0(strap[0]), .strap_select_bit1(strap[1]),
    .strap_select_bit2(strap[2]), .write_protect(wp), .busy(busy));
  i2cee_master i2cee_master_inst (.clk(clk), .sda(sda), .scl(scl), .sda_low(m_low));
  always #12.5 clk = !clk;
  // Compare and count
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Write n bytes from b at a; ok is the data acks
  task automatic wr(input logic [7:0] a, input int n, input logic [7:0] b, output logic ok);
    logic [7:0] r;
    logic k;
    ok = 1'b1;
    i2cee_master_inst.start();
    i2cee_master_inst.byte_x(dev_w, 1'b1, r, k);
    chk("address ack", 8'h1, k);
    i2cee_master_inst.byte_x(a, 1'b1, r, k);
    chk("word ack", 8'h1, k);
    for (int i = 0; i < n; i++) begin
      i2cee_master_inst.byte_x(b + 8'(i), 1'b1, r, k);
      ok &= k;
    end
    i2cee_master_inst.stop();
  endtask : wr
  // Read n bytes from a, compare with exp_pg
  task automatic rd(input logic [7:0] a, input int n);
    logic [7:0] r;
    logic k;
    i2cee_master_inst.start();
    i2cee_master_inst.byte_x(dev_w, 1'b1, r, k);
    i2cee_master_inst.byte_x(a, 1'b1, r, k);
    i2cee_master_inst.start();
    i2cee_master_inst.byte_x(dev_w | 8'h1, 1'b1, r, k);
    chk("read address ack", 8'h1, k);
    for (int i = 0; i < n; i++) begin
      i2cee_master_inst.byte_x(8'hff, i == n - 1, r, k);
      chk("read data", exp_pg[i], r);
    end
    i2cee_master_inst.stop();
  endtask : rd
  // Poll with own write address
  task automatic poll(input logic e);
    logic [7:0] r;
    logic k;
    i2cee_master_inst.start();
    i2cee_master_inst.byte_x(dev_w, 1'b1, r, k);
    i2cee_master_inst.stop();
    chk("poll ack", 8'(e), k);
  endtask : poll
  // Bounded wait for the program cycle to end
  task automatic wait_idle();
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk);
    chk("busy end", 8'h0, busy);
  endtask : wait_idle
  // Print counts and verdict
  task automatic end_of_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  // Watchdog
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    end_of_test();
  end
  // Main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    wp = 1'b0;
    strap = 3'b101;
    n_fail = 0;
    checks = 0;
    dev_w = {i2cee_pkg::TYPE_PATTERN, 3'b101, 1'b0};
    bad = '{{4'hb, 3'b101, 1'b0}, {i2cee_pkg::TYPE_PATTERN, 3'b100, 1'b0},
            {i2cee_pkg::TYPE_PATTERN, 3'b001, 1'b0}};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    chk("busy after reset", 8'h0, busy);
    repeat (2) @(posedge clk);
    i2cee_master_inst.byte_x(dev_w, 1'b1, d, ok);
    chk("ack without start", 8'h0, ok);
    i2cee_master_inst.stop();
    foreach (bad[i]) begin
      i2cee_master_inst.start();
      i2cee_master_inst.byte_x(bad[i], 1'b1, d, ok);
      chk("foreign address ack", 8'h0, ok);
      i2cee_master_inst.stop();
    end
    for (int i = 0; i < 18; i++) exp_pg[(5 + i) % 16] = 8'(i);
    wr(8'h25, 18, 8'h00, ok);
    chk("page data acks", 8'h1, ok);
    chk("busy at stop", 8'h1, busy);
    poll(1'b0);
    wait_idle();
    poll(1'b1);
    rd(8'h20, 16);
    wp <= 1'b1;
    wr(8'h90, 1, 8'h55, ok);
    chk("protected data ack", 8'h0, ok);
    chk("protected busy", 8'h0, busy);
    exp_pg[0] = i2cee_pkg::ERASED_BYTE;
    rd(8'h90, 1);
    wr(8'h10, 1, 8'h3c, ok);
    chk("lower half ack", 8'h1, ok);
    wait_idle();
    wp <= 1'b0;
    exp_pg[0] = 8'h3c;
    rd(8'h10, 1);
    wr(8'h30, 1, 8'h77, ok);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("busy in reset", 8'h0, busy);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    poll(1'b1);
    end_of_test();
  end
endmodule : i2cee_slave_bench
bind i2cee_slave i2cee_slave_sva #(.PROG_CYCLES(PROG_CYCLES)) i2cee_slave_sva_inst (
  .clk(clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .strap_select_bit0(strap_select_bit0),
  .strap_select_bit1(strap_select_bit1), .strap_select_bit2(strap_select_bit2),
  .write_protect(write_protect), .busy(busy));
`default_nettype wire

// >>> verification/i2cee_slave_sva.sv
// Pin-level assertions for the EEPROM slave
`timescale 1ns/10ps
`default_nettype none
module i2cee_slave_sva #(
  parameter int PROG_CYCLES = 100  // Program time in clocks
) (
  input wire logic clk,                // Clock
  input wire logic rst,                // Reset
  input wire logic scl_in,             // SCL pin
  input wire logic sda_in,             // SDA wire
  input wire logic sda_out,            // SDA value
  input wire logic sda_oe,             // SDA pull
  input wire logic strap_select_bit0,  // Strap 0
  input wire logic strap_select_bit1,  // Strap 1
  input wire logic strap_select_bit2,  // Strap 2
  input wire logic write_protect,      // Protect pin
  input wire logic busy                // Program flag
);
  logic [31:0] cnt_reg;   // Busy length
  logic [31:0] cnt_next;  // Next busy length
  logic        scl_reg;   // Last SCL
  logic        sda_reg;   // Last SDA
  logic        sel_reg;   // Inside a framed command
  logic        sel_next;  // Next framing flag
  // Framing and busy length
  always_comb begin
    cnt_next = busy ? cnt_reg + 32'h1 : 32'h0;
    sel_next = sel_reg;
    if (scl_in && scl_reg && sda_reg && !sda_in) begin
      sel_next = 1'b1;
    end else if (scl_in && scl_reg && !sda_reg && sda_in) begin
      sel_next = 1'b0;
    end
  end
  // Helper registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 32'h0;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      sel_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      scl_reg <= scl_in;
      sda_reg <= sda_in;
      sel_reg <= sel_next;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  rst_quiet_a: assert property (disable iff (1'b0) rst |-> !busy && !sda_oe)
    else $error("outputs active in reset");
  drive_low_a: assert property (sda_oe |-> !sda_out)
    else $error("SDA driven high");
  oe_after_fall_a: assert property ($changed(sda_oe) |-> !$past(scl_in, 2))
    else $error("SDA changed after SCL rise");
  oe_steady_a: assert property (scl_in && $past(scl_in, 2) |-> $stable(sda_oe))
    else $error("SDA moved while SCL high");
  ack_framed_a: assert property ($rose(sda_oe) |-> sel_reg)
    else $error("response outside a command");
  busy_silent_a: assert property (busy |-> !sda_oe)
    else $error("response while programming");
  busy_on_stop_a: assert property ($rose(busy) |-> !sel_reg && scl_in && sda_in)
    else $error("program cycle not at stop");
  busy_max_a: assert property (busy |-> cnt_reg < PROG_CYCLES)
    else $error("program cycle too long");
  busy_len_a: assert property ($fell(busy) |-> cnt_reg == PROG_CYCLES)
    else $error("program cycle wrong length");
  cover property ($rose(busy));
  cover property ($fell(busy));
  cover property ($rose(sda_oe));
endmodule : i2cee_slave_sva
`default_nettype wire

// >>> verilog/i2cee_slave.sv
// Two-wire serial EEPROM slave: protocol engine, page buffer and array
`timescale 1ns/10ps
`default_nettype none
module i2cee_slave #(
  parameter bit LARGE_VARIANT = 1'b0,                  // 0: 256 bytes, 1: 512 bytes
  parameter int PROG_CYCLES   = i2cee_pkg::PROG_CYCLES // Internal program time in cycles
) (
  input  wire logic clk,                     // System clock, 40 MHz
  input  wire logic rst,                     // Power-on reset, async, active high
  input  wire logic scl_in,                  // Serial clock pin
  input  wire logic sda_in,                  // Serial data pin level
  output var  logic sda_out,                 // Serial data output value, always low
  output var  logic sda_oe,                  // High while pulling SDA low
  input  wire logic strap_select_bit0,       // Device select strap 0
  input  wire logic strap_select_bit1,       // Device select strap 1
  input  wire logic strap_select_bit2,       // Device select strap 2
  input  wire logic write_protect,           // Upper half protect pin
  output var  logic busy                     // Internal program cycle running
);
  localparam int AW = LARGE_VARIANT ? 9 : 8; // Memory address width
  localparam int DEPTH = 1 << AW;            // Array size in bytes

  // Overview of the engine
  // Single system clock; SCL is only a sampled input
  // All pins except the async reset pass two flops before any decision
  // SCL and SDA edges found from synchronised copies
  // START: SDA falls while SCL stays high
  // STOP: SDA rises while SCL stays high
  // Both conditions need SCL high on two samples
  // Data bits never move while SCL is high
  // So a data bit never looks like START or STOP
  //
  // Bit counter
  // Counts 0 to 8 within a byte
  // Value 8 marks the ninth, acknowledge clock
  // Rising SCL shifts one bit in while below 8
  // Falling SCL at 8 decides the acknowledge
  // Next falling SCL ends the ninth clock
  // Counter returns to 0 there
  //
  // Acknowledge timing
  // Pull-low starts a few clocks after SCL falls
  // Pull-low ends a few clocks after the next fall
  // The level therefore stands across the whole high phase
  // Master samples it mid high, well after settling
  //
  // Address byte
  // Upper nibble must equal the type pattern
  // Strap bits compared after synchronising
  // Large variant: lowest strap slot is an address bit
  // Last bit picks read or write direction
  // A mismatch parks the engine until START or STOP
  //
  // Word byte
  // Loads the low eight pointer bits
  // Upper pointer bit kept from the address byte
  // Acknowledged unconditionally when selected
  //
  // Protect sampling
  // Level captured as the word byte's ninth clock ends
  // That is the last falling edge before data
  // Held for the rest of the write
  // Later pin changes cannot alter this write
  //
  // Data bytes
  // Each byte goes to the page buffer at the low nibble
  // A valid flag marks every buffered slot
  // Only the low nibble of the pointer advances
  // More than a page wraps and overwrites slots
  // Last byte written to a slot wins
  // Protected target: no acknowledge, write dropped
  //
  // Commit on STOP
  // Only a write with buffered bytes starts a cycle
  // Valid slots copied into the array together
  // Slots never written keep their old contents
  // Busy flag then holds for the program time
  //
  // While busy
  // START is ignored, so polling gets no acknowledge
  // SDA is never pulled during the cycle
  // STOP only returns the engine to idle
  //
  // Read path
  // Byte at the pointer loaded after address ack
  // Bits shifted out after each SCL fall
  // SDA released in the ninth clock for the master
  // Master acknowledge loads the next byte
  // Read pointer runs across the whole array
  // Master NoACK parks the engine until START or STOP
  //
  // Limitations
  // SCL phases must last several system clocks
  // No spike filter beyond the two-flop delay
  // Program time counted in system clocks

  // Elaboration check on the program time
  if (PROG_CYCLES < 1) begin : g_prog_check
    $error("PROG_CYCLES must be at least one");
  end

  // Input synchronisers, two flops each
  logic [1:0] scl_sync_reg, sda_sync_reg, wp_sync_reg;
  logic [1:0] a_sync0_reg, a_sync1_reg, a_sync2_reg;
  logic       scl_d_reg, sda_d_reg;          // Delayed stable copies for edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      wp_sync_reg  <= 2'h0;
      a_sync0_reg  <= 2'h0;
      a_sync1_reg  <= 2'h0;
      a_sync2_reg  <= 2'h0;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      wp_sync_reg  <= {wp_sync_reg[0], write_protect};
      a_sync0_reg  <= {a_sync0_reg[0], strap_select_bit0};
      a_sync1_reg  <= {a_sync1_reg[0], strap_select_bit1};
      a_sync2_reg  <= {a_sync2_reg[0], strap_select_bit2};
      scl_d_reg    <= scl_sync_reg[1];
      sda_d_reg    <= sda_sync_reg[1];
    end
  end

  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
  always_comb begin
    scl_s     = scl_sync_reg[1];
    sda_s     = sda_sync_reg[1];
    scl_rise  = scl_s & ~scl_d_reg;
    scl_fall  = ~scl_s & scl_d_reg;
    start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  end

  // Memory array and page buffer
  localparam int PAGE_BYTES_L = i2cee_pkg::PAGE_BYTES;
  logic [7:0]            mem [DEPTH] = '{default: i2cee_pkg::ERASED_BYTE}; // Erased array
  logic [7:0]            page_buf [PAGE_BYTES_L]; // Page write buffer
  logic [PAGE_BYTES_L-1:0] page_vld_reg, page_vld_next; // Buffered byte valid flags

  // Protocol state
  i2cee_pkg::i2cee_state_e state_reg, state_next;
  logic [3:0]    bit_cnt_reg, bit_cnt_next;  // Bit within byte, 8 is ack slot
  logic [7:0]    shift_reg, shift_next;      // Receive or transmit shift
  logic [AW-1:0] ptr_reg, ptr_next;          // Address pointer
  logic          ack_reg, ack_next;          // Drive ack in ninth clock
  logic          tx_reg, tx_next;            // Byte being sent by device
  logic          wp_hit_reg, wp_hit_next;    // Write rejected by protection
  logic          wp_smp_reg, wp_smp_next;    // Sampled protect level
  logic          sda_oe_next;                // Next pull-low request
  logic          prog_go;                    // Commit page at STOP
  logic          buf_wr;                     // Store a received byte
  logic [31:0]   prog_cnt_reg, prog_cnt_next;// Program timer
  logic          busy_next;                  // Next busy flag
  logic          addr_match;                 // Slave address matches
  logic [7:0]    rd_byte;                    // Array byte at pointer

  // Address compare against pattern and straps
  always_comb begin
    addr_match = (shift_reg[7:4] == i2cee_pkg::TYPE_PATTERN) &&
                 (shift_reg[3] == a_sync2_reg[1]) &&
                 (shift_reg[2] == a_sync1_reg[1]) &&
                 (LARGE_VARIANT || (shift_reg[1] == a_sync0_reg[1]));
    rd_byte    = mem[ptr_reg];
  end

  // Next-state logic of the protocol engine
  always_comb begin
    state_next    = state_reg;
    bit_cnt_next  = bit_cnt_reg;
    shift_next    = shift_reg;
    ptr_next      = ptr_reg;
    ack_next      = ack_reg;
    tx_next       = tx_reg;
    wp_hit_next   = wp_hit_reg;
    wp_smp_next   = wp_smp_reg;
    page_vld_next = page_vld_reg;
    sda_oe_next   = sda_oe;
    prog_go       = 1'b0;
    buf_wr        = 1'b0;
    busy_next     = busy;
    prog_cnt_next = prog_cnt_reg;
    // Program timer
    if (busy) begin
      if (prog_cnt_reg == 32'(PROG_CYCLES - 1)) begin
        busy_next = 1'b0;
      end else begin
        prog_cnt_next = prog_cnt_reg + 32'h1;
      end
    end
    if (start_det && !busy) begin
      state_next   = i2cee_pkg::I2CEE_ADDR;
      bit_cnt_next = 4'h0;
      ack_next     = 1'b0;
      tx_next      = 1'b0;
      sda_oe_next  = 1'b0;
      page_vld_next = '0;
    end else if (stop_det) begin
      if (state_reg == i2cee_pkg::I2CEE_WDATA && |page_vld_reg && !wp_hit_reg) begin
        prog_go       = 1'b1;
        busy_next     = 1'b1;
        prog_cnt_next = 32'h0;
      end
      state_next  = i2cee_pkg::I2CEE_IDLE;
      sda_oe_next = 1'b0;
    end else if (busy || state_reg == i2cee_pkg::I2CEE_IDLE
                 || state_reg == i2cee_pkg::I2CEE_SKIP) begin
      sda_oe_next = 1'b0;
    end else if (scl_rise) begin
      if (bit_cnt_reg < 4'h8) begin
        shift_next   = {shift_reg[6:0], sda_s};
        bit_cnt_next = bit_cnt_reg + 4'h1;
      end else if (tx_reg && sda_s) begin
        state_next = i2cee_pkg::I2CEE_SKIP;
      end
    end else if (scl_fall) begin
      if (bit_cnt_reg == 4'h8 && !ack_reg) begin
        // End of eighth bit: decide acknowledge
        unique case (state_reg)
          i2cee_pkg::I2CEE_ADDR: begin
            if (addr_match) begin
              ack_next    = 1'b1;
              sda_oe_next = 1'b1;
              if (LARGE_VARIANT) begin
                ptr_next[AW-1] = shift_reg[1];
              end
              tx_next = shift_reg[0];
            end else begin
              state_next = i2cee_pkg::I2CEE_SKIP;
            end
          end
          i2cee_pkg::I2CEE_WORD: begin
            ack_next      = 1'b1;
            sda_oe_next   = 1'b1;
            ptr_next[7:0] = shift_reg;
          end
          i2cee_pkg::I2CEE_WDATA: begin
            if (wp_smp_reg && ptr_reg[AW-1]) begin
              wp_hit_next = 1'b1;
              state_next  = i2cee_pkg::I2CEE_SKIP;
            end else begin
              ack_next    = 1'b1;
              sda_oe_next = 1'b1;
              buf_wr      = 1'b1;
              page_vld_next[ptr_reg[3:0]] = 1'b1;
            end
          end
          default: begin
            // Sent byte done: release SDA for master ack
            ack_next    = 1'b1;
            sda_oe_next = 1'b0;
          end
        endcase
      end else if (bit_cnt_reg == 4'h8) begin
        // End of ninth clock: release ack, move on
        ack_next     = 1'b0;
        bit_cnt_next = 4'h0;
        sda_oe_next  = 1'b0;
        unique case (state_reg)
          i2cee_pkg::I2CEE_ADDR: begin
            state_next  = tx_reg ? i2cee_pkg::I2CEE_RDATA : i2cee_pkg::I2CEE_WORD;
            wp_hit_next = 1'b0;
            if (tx_reg) begin
              shift_next  = rd_byte;
              sda_oe_next = ~rd_byte[7];
            end
          end
          i2cee_pkg::I2CEE_WORD: begin
            state_next  = i2cee_pkg::I2CEE_WDATA;
            wp_smp_next = wp_sync_reg[1];
          end
          i2cee_pkg::I2CEE_WDATA: begin
            ptr_next[3:0] = ptr_reg[3:0] + 4'h1;
          end
          default: begin
            shift_next  = mem[ptr_reg + AW'(1)];
            ptr_next    = ptr_reg + AW'(1);
            sda_oe_next = ~shift_next[7];
          end
        endcase
      end else if (tx_reg && state_reg == i2cee_pkg::I2CEE_RDATA) begin
        sda_oe_next = ~shift_reg[7];
      end
    end
  end

  // Register the protocol engine
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg    <= i2cee_pkg::I2CEE_IDLE;
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= 8'h00;
      ptr_reg      <= '0;
      ack_reg      <= 1'b0;
      tx_reg       <= 1'b0;
      wp_hit_reg   <= 1'b0;
      wp_smp_reg   <= 1'b0;
      page_vld_reg <= '0;
      sda_oe       <= 1'b0;
      busy         <= 1'b0;
      prog_cnt_reg <= 32'h0;
    end else begin
      state_reg    <= state_next;
      bit_cnt_reg  <= bit_cnt_next;
      shift_reg    <= shift_next;
      ptr_reg      <= ptr_next;
      ack_reg      <= ack_next;
      tx_reg       <= tx_next;
      wp_hit_reg   <= wp_hit_next;
      wp_smp_reg   <= wp_smp_next;
      page_vld_reg <= page_vld_next;
      sda_oe       <= sda_oe_next;
      busy         <= busy_next;
      prog_cnt_reg <= prog_cnt_next;
    end
  end

  // Open-drain data output is always a low level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // Page buffer store, overwriting on wrap
  always_ff @(posedge clk) begin
    if (buf_wr) begin
      page_buf[ptr_reg[3:0]] <= shift_reg;
    end
  end

  // Array: valid page slots committed on STOP
  always_ff @(posedge clk) begin
    for (int j = 0; j < PAGE_BYTES_L; j++) begin
      if (prog_go && page_vld_reg[j]) begin
        mem[{ptr_reg[AW-1:4], 4'(j)}] <= page_buf[j];
      end
    end
  end
endmodule : i2cee_slave
`default_nettype wire
